// *** slp_regs.sv ***
// serial link parameter register bank with receive descrambler
// ------------------------------------------------------------
// How it works
// RQ1: bit 7 set descrambles, clear passes through
// RQ2: software writes fields only during decoder soft reset
// RQ3: lane count minus one reads 7, read-only
// RQ4: octets per frame read-only zero, unused
// RQ5: frames per multiframe minus one, resets 31
// RQ6: converters minus one read-only, reads one
// RQ7: control bits per sample read zero
// RQ8: resolution minus one fixed at 0x0F
// RQ9: latency class 0 or 1; 2 refused
// RQ10: bits per sample minus one fixed 0x0F
// RQ11: software writes configuration checksum elsewhere
// RQ12: reserved and read-only bits ignore writes
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module slp_regs (
  input  wire logic                          REF_CLK,
  input  wire logic                          NRST,
  input  wire logic [slp_pkg::ADDR_W-1:0]    CFG_ADDR,
  input  wire logic [slp_pkg::DATA_W-1:0]    CFG_WDATA,
  input  wire logic                          CFG_WR,
  input  wire logic                          CFG_RD,
  output logic [slp_pkg::DATA_W-1:0]         CFG_RDATA,
  output logic                               CFG_RD_VALID,
  input  wire logic                          LINK_DECODER_SOFT_RST,
  input  wire logic [slp_pkg::DATA_W-1:0]    RX_OCTET,
  input  wire logic                          RX_OCTET_VALID,
  output logic [slp_pkg::DATA_W-1:0]         RX_DATA,
  output logic                               RX_DATA_VALID,
  output logic                               DESCRAMBLE_EN,
  output logic [slp_pkg::LANES_W-1:0]        LANE_COUNT_M1,
  output logic [slp_pkg::MF_W-1:0]           MULTIFRAME_FRAMES_M1,
  output logic [slp_pkg::DATA_W-1:0]         CONVERTER_COUNT_M1,
  output logic [slp_pkg::CLASS_W-1:0]        DET_LATENCY_CLASS,
  output logic [slp_pkg::SAMPLE_W-1:0]       BITS_PER_SAMPLE_M1
);
  import slp_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  slp_wr_if                   wr_bus ();
  logic                       we_unmix;
  logic                       we_mf;
  logic                       we_class;
  logic                       class_ok;
  logic [0:0]                 unmix_reg;
  logic [MF_W-1:0]            mf_reg;
  logic [CLASS_W-1:0]         class_reg;
  logic [DATA_W-1:0]          rdata_next;
  logic [DATA_W-1:0]          rdata_reg;
  logic                       rd_valid_reg;
  logic [HIST_W-1:0]          hist_reg;
  logic [HIST_W-1:0]          hist_next;
  logic [DATA_W-1:0]          plain_next;
  logic [DATA_W-1:0]          rx_data_reg;
  logic                       rx_valid_reg;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  assign wr_bus.wdata = CFG_WDATA;

  always_comb begin
    we_unmix = 1'b0;
    we_mf    = 1'b0;
    we_class = 1'b0;
    if (CFG_WR && (CFG_ADDR == ADDR_UNMIX_AND_LANES)) begin
      we_unmix = 1'b1;
    end else if (CFG_WR && (CFG_ADDR == ADDR_MULTIFRAME_LENGTH)) begin
      we_mf = 1'b1;
    end else if (CFG_WR && (CFG_ADDR == ADDR_SUBCLASS_AND_SAMPLES)) begin
      we_class = 1'b1;
    end
  end

  // unsupported class codes leave the field as it was
  assign class_ok = (CFG_WDATA[CLASS_LSB +: CLASS_W] <= CLASS_MAX);  // see RQ9

  // ------------------------------------------------------------
  // writable fields
  // ------------------------------------------------------------
  // see RQ1
  slp_field #(
    .W     (1),
    .LSB   (UNMIX_BIT),
    .RESET (UNMIX_RESET)
  ) u_unmix (
    .REF_CLK   (REF_CLK),
    .NRST      (NRST),
    .bus       (wr_bus.field),
    .we        (we_unmix),
    .allow     (1'b1),
    .value_reg (unmix_reg)
  );

  // see RQ5
  slp_field #(
    .W     (MF_W),
    .LSB   (0),
    .RESET (MF_RESET)
  ) u_mf (
    .REF_CLK   (REF_CLK),
    .NRST      (NRST),
    .bus       (wr_bus.field),
    .we        (we_mf),
    .allow     (1'b1),
    .value_reg (mf_reg)
  );

  // see RQ9
  slp_field #(
    .W     (CLASS_W),
    .LSB   (CLASS_LSB),
    .RESET (CLASS_RESET)
  ) u_class (
    .REF_CLK   (REF_CLK),
    .NRST      (NRST),
    .bus       (wr_bus.field),
    .we        (we_class),
    .allow     (class_ok),
    .value_reg (class_reg)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (CFG_ADDR == ADDR_UNMIX_AND_LANES) begin
      rdata_next[UNMIX_BIT]      = unmix_reg[0];
      rdata_next[LANES_W-1:0]    = LANES_M1_VALUE;  // see RQ3
    end else if (CFG_ADDR == ADDR_FRAME_OCTETS) begin
      rdata_next = FRAME_OCTETS_VALUE;  // see RQ4
    end else if (CFG_ADDR == ADDR_MULTIFRAME_LENGTH) begin
      rdata_next[MF_W-1:0] = mf_reg;  // see RQ5
    end else if (CFG_ADDR == ADDR_CONVERTER_TOTAL) begin
      rdata_next = CONVERTERS_M1_VALUE;  // see RQ6
    end else if (CFG_ADDR == ADDR_CTRL_BITS_AND_RES) begin
      rdata_next[CTRL_LSB +: CTRL_W] = CTRL_BITS_VALUE;  // see RQ7
      rdata_next[RES_W-1:0]          = RESOLUTION_M1_VALUE;  // see RQ8
    end else if (CFG_ADDR == ADDR_SUBCLASS_AND_SAMPLES) begin
      rdata_next[CLASS_LSB +: CLASS_W] = class_reg;
      rdata_next[SAMPLE_W-1:0]         = SAMPLE_BITS_M1_VALUE;  // see RQ10
    end
    // unmapped and reserved bits stay zero, see RQ12
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_reg    <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= CFG_RD;
      if (CFG_RD) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign CFG_RDATA    = rdata_reg;
  assign CFG_RD_VALID = rd_valid_reg;

  // ------------------------------------------------------------
  // self-synchronous descrambler, msb first
  // ------------------------------------------------------------
  always_comb begin
    hist_next  = hist_reg;
    plain_next = '0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      plain_next[i] = RX_OCTET[i] ^ hist_next[TAP_A] ^ hist_next[TAP_B];
      hist_next     = {hist_next[HIST_W-2:0], RX_OCTET[i]};
    end
  end

  // history is flushed while the decoder sits in soft reset, see RQ2
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      hist_reg <= '0;
    end else if (LINK_DECODER_SOFT_RST) begin
      hist_reg <= '0;
    end else if (RX_OCTET_VALID) begin
      hist_reg <= hist_next;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_data_reg  <= '0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= RX_OCTET_VALID && !LINK_DECODER_SOFT_RST;
      if (RX_OCTET_VALID && !LINK_DECODER_SOFT_RST) begin
        rx_data_reg <= unmix_reg[0] ? plain_next : RX_OCTET;  // see RQ1
      end
    end
  end

  assign RX_DATA       = rx_data_reg;
  assign RX_DATA_VALID = rx_valid_reg;

  // ------------------------------------------------------------
  // parameter outputs
  // ------------------------------------------------------------
  assign DESCRAMBLE_EN        = unmix_reg[0];
  assign LANE_COUNT_M1        = LANES_M1_VALUE;
  assign MULTIFRAME_FRAMES_M1 = mf_reg;
  assign CONVERTER_COUNT_M1   = CONVERTERS_M1_VALUE;
  assign DET_LATENCY_CLASS    = class_reg;
  assign BITS_PER_SAMPLE_M1   = SAMPLE_BITS_M1_VALUE;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_unmix_write: assert property (  // see RQ1
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_WR && CFG_ADDR == ADDR_UNMIX_AND_LANES)
      |=> DESCRAMBLE_EN == $past(CFG_WDATA[UNMIX_BIT]))
    else $error("unmix enable did not follow its write");

  a_bypass_path: assert property (  // see RQ1
    @(posedge REF_CLK) disable iff (!NRST)
    (RX_OCTET_VALID && !LINK_DECODER_SOFT_RST && !DESCRAMBLE_EN)
      |=> RX_DATA_VALID && RX_DATA == $past(RX_OCTET))
    else $error("disabled descrambler altered data");

  a_lane_read: assert property (  // see RQ3
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_RD && CFG_ADDR == ADDR_UNMIX_AND_LANES)
      |=> CFG_RD_VALID && CFG_RDATA[6:0] == 7'h07)
    else $error("lane field or reserved bits read wrong");

  a_octets_read: assert property (  // see RQ4
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_RD && CFG_ADDR == ADDR_FRAME_OCTETS) |=> CFG_RDATA == 8'h00)
    else $error("octets per frame read nonzero");

  a_mf_write: assert property (  // see RQ5
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_WR && CFG_ADDR == ADDR_MULTIFRAME_LENGTH) ##1
    (CFG_RD && CFG_ADDR == ADDR_MULTIFRAME_LENGTH && !CFG_WR)
      |=> CFG_RDATA == {3'h0, $past(CFG_WDATA[4:0], 2)})
    else $error("multiframe length read back wrong");

  a_conv_read: assert property (  // see RQ6
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_RD && CFG_ADDR == ADDR_CONVERTER_TOTAL) |=> CFG_RDATA == 8'h01)
    else $error("converter count read wrong");

  a_res_read: assert property (  // see RQ7
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_RD && CFG_ADDR == ADDR_CTRL_BITS_AND_RES) |=> CFG_RDATA == 8'h0F)
    else $error("control bits or resolution read wrong");

  a_class_guard: assert property (  // see RQ9
    @(posedge REF_CLK) disable iff (!NRST)
    (we_class && CFG_WDATA[7:5] > 3'h1)
      |=> $stable(DET_LATENCY_CLASS) && DET_LATENCY_CLASS <= 3'h1)
    else $error("unsupported latency class accepted");

  a_np_read: assert property (  // see RQ10
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_RD && CFG_ADDR == ADDR_SUBCLASS_AND_SAMPLES)
      |=> CFG_RDATA[4:0] == 5'h0F && CFG_RDATA[7:5] == $past(DET_LATENCY_CLASS))
    else $error("bits per sample read wrong");

  a_unmapped_zero: assert property (  // see RQ12
    @(posedge REF_CLK) disable iff (!NRST)
    (CFG_RD && (CFG_ADDR < ADDR_UNMIX_AND_LANES || CFG_ADDR > ADDR_SUBCLASS_AND_SAMPLES))
      |=> CFG_RDATA == 8'h00)
    else $error("unmapped address read nonzero");

  a_class_range: assert property (  // see RQ9
    @(posedge REF_CLK) disable iff (!NRST)
    DET_LATENCY_CLASS <= 3'h1)
    else $error("latency class outside supported codes");

  a_class_hold: assert property (  // see RQ9
    @(posedge REF_CLK) disable iff (!NRST)
    !we_class |=> $stable(DET_LATENCY_CLASS))
    else $error("latency class moved without a write");

  a_mf_hold: assert property (  // see RQ5
    @(posedge REF_CLK) disable iff (!NRST)
    !(CFG_WR && CFG_ADDR == ADDR_MULTIFRAME_LENGTH) |=> $stable(MULTIFRAME_FRAMES_M1))
    else $error("multiframe length moved without a write");

  a_unmix_hold: assert property (  // see RQ1
    @(posedge REF_CLK) disable iff (!NRST)
    !(CFG_WR && CFG_ADDR == ADDR_UNMIX_AND_LANES) |=> $stable(DESCRAMBLE_EN))
    else $error("unmix enable moved without a write");

  a_rx_accept: assert property (  // see RQ1
    @(posedge REF_CLK) disable iff (!NRST)
    (RX_OCTET_VALID && !LINK_DECODER_SOFT_RST) |=> RX_DATA_VALID)
    else $error("accepted octet produced no output");

  a_rx_drop: assert property (  // see RQ1
    @(posedge REF_CLK) disable iff (!NRST)
    (!RX_OCTET_VALID || LINK_DECODER_SOFT_RST) |=> !RX_DATA_VALID)
    else $error("output valid without an accepted octet");
endmodule
`default_nettype wire

// *** slp_pkg.sv ***
// constants for the serial link parameter register bank
package slp_pkg;
  // ------------------------------------------------------------
  // configuration port
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_UNMIX_AND_LANES      = 12'h453;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_OCTETS         = 12'h454;
  localparam logic [ADDR_W-1:0] ADDR_MULTIFRAME_LENGTH    = 12'h455;
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER_TOTAL      = 12'h456;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_BITS_AND_RES    = 12'h457;
  localparam logic [ADDR_W-1:0] ADDR_SUBCLASS_AND_SAMPLES = 12'h458;

  // ------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------
  localparam int UNMIX_BIT   = 7;
  localparam int LANES_W     = 5;
  localparam int MF_W        = 5;
  localparam int CTRL_LSB    = 6;
  localparam int CTRL_W      = 2;
  localparam int RES_W       = 5;
  localparam int CLASS_LSB   = 5;
  localparam int CLASS_W     = 3;
  localparam int SAMPLE_W    = 5;

  // ------------------------------------------------------------
  // reset and fixed values
  // ------------------------------------------------------------
  localparam logic [0:0]          UNMIX_RESET        = 1'h1;
  localparam logic [LANES_W-1:0]  LANES_M1_VALUE     = 5'h07;
  localparam logic [DATA_W-1:0]   FRAME_OCTETS_VALUE = 8'h00;
  localparam logic [MF_W-1:0]     MF_RESET           = 5'h1F;
  localparam logic [DATA_W-1:0]   CONVERTERS_M1_VALUE = 8'h01;
  localparam logic [CTRL_W-1:0]   CTRL_BITS_VALUE    = 2'h0;
  localparam logic [RES_W-1:0]    RESOLUTION_M1_VALUE = 5'h0F;
  localparam logic [CLASS_W-1:0]  CLASS_RESET        = 3'h0;
  localparam logic [CLASS_W-1:0]  CLASS_MAX          = 3'h1;
  localparam logic [SAMPLE_W-1:0] SAMPLE_BITS_M1_VALUE = 5'h0F;

  // ------------------------------------------------------------
  // descrambler polynomial 1 + x^14 + x^15
  // ------------------------------------------------------------
  localparam int HIST_W  = 15;
  localparam int TAP_A   = 13;
  localparam int TAP_B   = 14;
endpackage

// *** slp_wr_if.sv ***
// write data carrier between the bank and its writable fields
`timescale 1ns/100ps
`default_nettype none
interface slp_wr_if;
  logic [slp_pkg::DATA_W-1:0] wdata;
  modport ctrl  (output wdata);
  modport field (input  wdata);
endinterface
`default_nettype wire

// *** slp_field.sv ***
// one writable register field with reset value and write guard
`timescale 1ns/100ps
`default_nettype none
module slp_field #(
  parameter int       W     = 1,
  parameter int       LSB   = 0,
  parameter logic [W-1:0] RESET = '0
) (
  input  wire logic          REF_CLK,
  input  wire logic          NRST,
  slp_wr_if.field            bus,
  input  wire logic          we,
  input  wire logic          allow,
  output logic [W-1:0]       value_reg
);
  import slp_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      value_reg <= RESET;
    end else if (we && allow) begin
      value_reg <= bus.wdata[LSB +: W];
    end
  end
endmodule
`default_nettype wire

// *** slp_link_tx.sv ***
// transmitter side model: scrambles octets and drives the receive pins
`timescale 1ns/100ps
`default_nettype none
module slp_link_tx (
  output logic [slp_pkg::DATA_W-1:0] rx_octet,
  output logic                       rx_octet_valid
);
  import slp_pkg::*;
  logic [HIST_W-1:0] hist;
  logic [DATA_W-1:0] last;
  initial begin
    hist = '0;
    last = 8'h00;
    rx_octet = 8'h00;
    rx_octet_valid = 1'b0;
  end
  // ------------------------------------------------------------
  // scrambler, msb first, history over the sent stream
  // ------------------------------------------------------------
  task automatic clr();
    hist = '0;
  endtask
  task automatic put(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] s;
    int                i;
    for (i = DATA_W - 1; i >= 0; i--) begin
      s[i] = d[i] ^ hist[TAP_A] ^ hist[TAP_B];
      hist = {hist[HIST_W-2:0], s[i]};
    end
    last = s;
    rx_octet = s;
    rx_octet_valid = 1'b1;
  endtask
  // released lines show the inverse, not a stale copy
  task automatic idle();
    rx_octet = ~last;
    rx_octet_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** slp_regs_tb.sv ***
// self-checking bench for the serial link parameter bank
`timescale 1ns/100ps
`default_nettype none
module slp_regs_tb;
  import slp_pkg::*;
  logic                ref_clk, nrst, cfg_wr, cfg_rd, soft_rst;
  logic [ADDR_W-1:0]   cfg_addr;
  logic [DATA_W-1:0]   cfg_wdata, cfg_rdata, rx_octet, rx_data, conv_m1;
  logic                cfg_rd_valid, rx_octet_valid, rx_data_valid, desc_en;
  logic [LANES_W-1:0]  lane_m1;
  logic [MF_W-1:0]     mf_m1;
  logic [CLASS_W-1:0]  det_class;
  logic [SAMPLE_W-1:0] bps_m1;
  int                  err_count, checks_done;
  logic [ADDR_W-1:0]   i;
  logic [7:0]          cks;
  logic [7:0]          rst_v [6] = '{8'h87, 8'h00, 8'h1F, 8'h01, 8'h0F, 8'h0F};
  logic [7:0]          zer_v [6] = '{8'h07, 8'h00, 8'h00, 8'h01, 8'h0F, 8'h0F};
  logic [7:0]          pl [8] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01, 8'h80, 8'h3C, 8'hC3};
  logic [7:0]          sc [8];

  slp_regs dut (
    .REF_CLK(ref_clk), .NRST(nrst), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
    .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_RDATA(cfg_rdata), .CFG_RD_VALID(cfg_rd_valid),
    .LINK_DECODER_SOFT_RST(soft_rst), .RX_OCTET(rx_octet), .RX_OCTET_VALID(rx_octet_valid),
    .RX_DATA(rx_data), .RX_DATA_VALID(rx_data_valid), .DESCRAMBLE_EN(desc_en),
    .LANE_COUNT_M1(lane_m1), .MULTIFRAME_FRAMES_M1(mf_m1), .CONVERTER_COUNT_M1(conv_m1),
    .DET_LATENCY_CLASS(det_class), .BITS_PER_SAMPLE_M1(bps_m1)
  );
  slp_link_tx tx (.rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk(8'(cfg_rd_valid), 8'h01);
    chk(cfg_rdata, exp);
    @(negedge ref_clk);
    chk(8'(cfg_rd_valid), 8'h00);
  endtask
  // back-to-back octets, each answered one cycle later
  task automatic stream(input logic unmix);
    int k;
    for (k = 0; k <= 8; k++) begin
      @(negedge ref_clk);
      if (k > 0) begin
        chk(8'(rx_data_valid), 8'h01);
        chk(rx_data, unmix ? pl[k-1] : sc[k-1]);
      end
      if (k < 8) begin
        tx.put(pl[k]);
        sc[k] = tx.last;
      end else tx.idle();
    end
    @(negedge ref_clk);
    chk(8'(rx_data_valid), 8'h00);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    checks_done = 0;
    nrst = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    soft_rst = 1'b1;
    cfg_addr = '0;
    cfg_wdata = '0;
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    chk(8'(desc_en), 8'h01);
    chk(8'(lane_m1), 8'h07);
    chk(8'(mf_m1), 8'h1F);
    chk(conv_m1, 8'h01);
    chk(8'(det_class), 8'h00);
    chk(8'(bps_m1), 8'h0F);
    for (i = '0; i < 6; i++) rdc(ADDR_UNMIX_AND_LANES + i, rst_v[i]);
    for (i = '0; i < 6; i++) wr(ADDR_UNMIX_AND_LANES + i, 8'h00);
    for (i = '0; i < 6; i++) rdc(ADDR_UNMIX_AND_LANES + i, zer_v[i]);
    chk(8'(desc_en), 8'h00);
    chk(8'(mf_m1), 8'h00);
    for (i = '0; i < 6; i++) wr(ADDR_UNMIX_AND_LANES + i, 8'hFF);
    for (i = '0; i < 6; i++) rdc(ADDR_UNMIX_AND_LANES + i, rst_v[i]);
    chk(8'(det_class), 8'h00);
    wr(ADDR_MULTIFRAME_LENGTH, 8'h0F);
    rdc(ADDR_MULTIFRAME_LENGTH, 8'h0F);
    wr(ADDR_MULTIFRAME_LENGTH, 8'h1F);
    chk(8'(mf_m1), 8'h1F);
    // write then read in the very next cycle
    @(negedge ref_clk);
    cfg_addr = ADDR_MULTIFRAME_LENGTH;
    cfg_wdata = 8'h0F;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk(cfg_rdata, 8'h0F);
    wr(ADDR_SUBCLASS_AND_SAMPLES, 8'h20);
    rdc(ADDR_SUBCLASS_AND_SAMPLES, 8'h2F);
    wr(ADDR_SUBCLASS_AND_SAMPLES, 8'h40);
    chk(8'(det_class), 8'h01);
    cks = 8'h00;
    for (i = '0; i < 6; i++) cks = cks + rst_v[i];
    wr(12'h45D, cks);
    rdc(12'h45D, 8'h00);
    @(negedge ref_clk);
    tx.put(8'h77);
    @(negedge ref_clk);
    tx.idle();
    chk(8'(rx_data_valid), 8'h00);
    tx.clr();
    soft_rst = 1'b0;
    stream(1'b1);
    @(negedge ref_clk);
    soft_rst = 1'b1;
    wr(ADDR_UNMIX_AND_LANES, 8'h07);
    chk(8'(desc_en), 8'h00);
    @(negedge ref_clk);
    soft_rst = 1'b0;
    tx.clr();
    stream(1'b0);
    // mid-run reset returns written fields to their reset values
    @(negedge ref_clk);
    nrst = 1'b0;
    @(negedge ref_clk);
    nrst = 1'b1;
    chk(8'(desc_en), 8'h01);
    chk(8'(mf_m1), 8'h1F);
    chk(8'(det_class), 8'h00);
    chk(rx_data, 8'h00);
    rdc(ADDR_UNMIX_AND_LANES, 8'h87);
    print_verdict();
  end
endmodule
`default_nettype wire
